// ===== pbs_pkg.sv
// constants and types for the pipelined burst sram port
package pbs_pkg;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int BURST_W = 2;
  localparam int DEPTH   = 65536;

  localparam logic [BURST_W-1:0] BEAT_RST    = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP   = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL   = 4'hF;
  localparam logic [LANES-1:0]   LANES_NONE  = 4'h0;
  localparam logic               STROBE_RST  = 1'h1;
  localparam logic               ENABLE_RST  = 1'h0;
  localparam logic               LOWPWR_RST  = 1'h0;
  localparam logic               RDVALID_RST = 1'h0;
  localparam logic [DATA_W-1:0]  DATA_RST    = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  ADDR_RST    = 16'h0000;

  typedef enum logic [2:0] {
    PBS_IDLE  = 3'h1,
    PBS_READ  = 3'h2,
    PBS_WRITE = 3'h4
  } pbs_state_e;

  // low = linear (add beat), high = interleaved (xor beat)
  function automatic logic [BURST_W-1:0] pbs_burst_bits(input logic [BURST_W-1:0] start,
                                                        input logic [BURST_W-1:0] beat,
                                                        input logic               order);
    pbs_burst_bits = order ? (start ^ beat) : BURST_W'(start + beat);
  endfunction
endpackage

// ===== pbs_burst_if.sv
// link between the port control and its burst counter
`timescale 1ns/100ps
`default_nettype none
interface pbs_burst_if;
  import pbs_pkg::*;
  logic               load;
  logic [BURST_W-1:0] load_bits;
  logic               step;
  logic               order;
  logic [BURST_W-1:0] cur_bits;
  logic [BURST_W-1:0] next_bits;
  modport ctl (output load, load_bits, step, order, input cur_bits, next_bits);
  modport ctr (input load, load_bits, step, order, output cur_bits, next_bits);
endinterface
`default_nettype wire

// ===== pbs_burst_ctr.sv
// two-bit burst address counter, linear or interleaved
`timescale 1ns/100ps
`default_nettype none
module pbs_burst_ctr
  import pbs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control side
  pbs_burst_if.ctr  bus
);
  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] beat_reg;
  logic [BURST_W-1:0] beat_next;

  assign beat_next     = BURST_W'(beat_reg + BEAT_STEP);
  // order is used live, never stored
  assign bus.cur_bits  = pbs_burst_bits(start_reg, beat_reg, bus.order);
  assign bus.next_bits = pbs_burst_bits(start_reg, beat_next, bus.order);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= BEAT_RST;
      beat_reg  <= BEAT_RST;
    end else if (bus.load) begin
      start_reg <= bus.load_bits;
      beat_reg  <= BEAT_RST;
    end else if (bus.step) begin
      beat_reg  <= beat_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_linear_step: assert property ((bus.step && !bus.load && !bus.order)
    |=> bus.cur_bits == BURST_W'($past(bus.cur_bits) + BEAT_STEP))
    else $error("linear burst did not add one");
  chk_interleave_step: assert property ((bus.step && !bus.load && bus.order)
    |=> (bus.cur_bits ^ start_reg) == BURST_W'(($past(bus.cur_bits) ^ start_reg) + BEAT_STEP))
    else $error("interleaved burst beat wrong");
  chk_load_start: assert property (bus.load |=> beat_reg == BEAT_RST && start_reg == $past(bus.load_bits))
    else $error("burst start not loaded");
endmodule
`default_nettype wire

// ===== pbs_sram_port.sv
// pipelined burst static ram port, 64k words by 32 bits
// Summary of operation
// - 65536 words of 32 bits, four lanes
// - two-bit burst counter makes later beat addresses
// - address, data, controls registered on rising edge, except order select, which the counter uses unsampled
// - either address strobe starts a burst
// - burst advance low steps the counter
// - order select low linear, high interleaved
// - writes self-timed from the sampling edge
// - qualifier writes only lanes with byte write
// - global or all bytes write every lane
// - read data through output register, one clock
// - controller strobe loads address: read, write, deselect
// - processor strobe reads only, blocked by enable1 high
// - bidirectional data, eight lines per lane
// - start with any enable inactive deselects
// - global write overrides byte controls
// - sleep freezes logic, low power until access
// - output enable acts unsampled on the drivers
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_port
  import pbs_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // address and strobes
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              controller_addr_strobe_n,
  input  wire logic              processor_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              burst_order_select,
  // chip enables
  input  wire logic              chip_enable1_n,
  input  wire logic              chip_enable2,
  input  wire logic              chip_enable3_n,
  // write controls
  input  wire logic [LANES-1:0]  byte_write_n,
  input  wire logic              global_write_n,
  input  wire logic              byte_write_qualifier_n,
  // asynchronous controls
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  // data lanes, split into in, out and enable
  input  wire logic [DATA_W-1:0] data_byte_lanes_in,
  output logic      [DATA_W-1:0] data_byte_lanes_out,
  output logic                   data_byte_lanes_oe,
  // status
  output logic                   low_power
);
  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // sampled inputs
  logic [ADDR_W-1:0] s_addr_reg;
  logic [DATA_W-1:0] s_data_reg;
  logic              s_controller_addr_strobe_n_n_reg;
  logic              s_processor_addr_strobe_n_n_reg;
  logic              s_adv_n_reg;
  logic              s_ce1_n_reg;
  logic              s_ce2_reg;
  logic              s_ce3_n_reg;
  logic [LANES-1:0]  s_bw_n_reg;
  logic              s_gw_n_reg;
  logic              s_bwq_n_reg;

  pbs_state_e          state_reg;
  pbs_state_e          state_next;
  logic [ADDR_W-1:2]   base_reg;
  logic [DATA_W-1:0]   rd_data_reg;
  logic                rd_valid_reg;
  logic                rd_valid_next;
  logic                low_power_reg;
  logic                low_power_next;

  pbs_burst_if burst ();

  pbs_burst_ctr u_ctr (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (burst)
  );

  // sleep stands in for a stopped internal clock
  wire run = !sleep_request;

  wire en_ok     = !s_ce1_n_reg && s_ce2_reg && !s_ce3_n_reg;
  wire processor_addr_strobe_n_take = !s_processor_addr_strobe_n_n_reg && !s_ce1_n_reg;
  wire controller_addr_strobe_n_take = !s_controller_addr_strobe_n_n_reg && !processor_addr_strobe_n_take;
  wire start     = processor_addr_strobe_n_take || controller_addr_strobe_n_take;
  wire begin_acc = run && start && en_ok;
  wire deselect  = run && start && !en_ok;
  wire active    = run && !start && (state_reg != PBS_IDLE) && !low_power_reg;

  // global write wins over byte controls
  wire [LANES-1:0] lane_we = !s_gw_n_reg ? LANES_ALL :
                             (!s_bwq_n_reg ? ~s_bw_n_reg : LANES_NONE);
  wire wr_cmd   = |lane_we;
  wire begin_rd = begin_acc && (processor_addr_strobe_n_take || !wr_cmd);
  wire begin_wr = begin_acc && controller_addr_strobe_n_take && wr_cmd;
  wire step     = active && !s_adv_n_reg;
  wire op_read  = begin_rd || (active && !wr_cmd);
  wire op_write = begin_wr || (active && wr_cmd);

  assign burst.load      = begin_acc;
  assign burst.load_bits = s_addr_reg[1:0];
  assign burst.step      = step;
  assign burst.order     = burst_order_select;

  // suspended beats reuse the current bits
  wire [BURST_W-1:0] eff_low  = begin_acc ? s_addr_reg[1:0] :
                                (step ? burst.next_bits : burst.cur_bits);
  wire [ADDR_W-1:2]  eff_high = begin_acc ? s_addr_reg[ADDR_W-1:2] : base_reg;
  wire [ADDR_W-1:0]  eff_addr = {eff_high, eff_low};
  wire [DATA_W-1:0]  rd_word  = mem[eff_addr];

  always_comb begin
    state_next = state_reg;
    if (deselect) begin
      state_next = PBS_IDLE;
    end else if (op_write) begin
      state_next = PBS_WRITE;
    end else if (op_read) begin
      state_next = PBS_READ;
    end
  end

  always_comb begin
    rd_valid_next = rd_valid_reg;
    if (low_power_reg && !begin_acc) begin
      rd_valid_next = 1'h0;
    end else if (op_read) begin
      rd_valid_next = 1'h1;
    end else if (op_write || deselect) begin
      rd_valid_next = 1'h0;
    end
  end

  assign low_power_next = sleep_request ? 1'h1 : (begin_acc ? 1'h0 : low_power_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_addr_reg   <= ADDR_RST;
      s_data_reg   <= DATA_RST;
      s_controller_addr_strobe_n_n_reg <= STROBE_RST;
      s_processor_addr_strobe_n_n_reg <= STROBE_RST;
      s_adv_n_reg  <= STROBE_RST;
      s_ce1_n_reg  <= STROBE_RST;
      s_ce2_reg    <= ENABLE_RST;
      s_ce3_n_reg  <= STROBE_RST;
      s_bw_n_reg   <= LANES_ALL;
      s_gw_n_reg   <= STROBE_RST;
      s_bwq_n_reg  <= STROBE_RST;
    end else if (run) begin
      s_addr_reg   <= address_in;
      s_data_reg   <= data_byte_lanes_in;
      s_controller_addr_strobe_n_n_reg <= controller_addr_strobe_n;
      s_processor_addr_strobe_n_n_reg <= processor_addr_strobe_n;
      s_adv_n_reg  <= burst_advance_n;
      s_ce1_n_reg  <= chip_enable1_n;
      s_ce2_reg    <= chip_enable2;
      s_ce3_n_reg  <= chip_enable3_n;
      s_bw_n_reg   <= byte_write_n;
      s_gw_n_reg   <= global_write_n;
      s_bwq_n_reg  <= byte_write_qualifier_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= PBS_IDLE;
      base_reg      <= ADDR_RST[ADDR_W-1:2];
      rd_data_reg   <= DATA_RST;
      rd_valid_reg  <= RDVALID_RST;
      low_power_reg <= LOWPWR_RST;
    end else begin
      low_power_reg <= low_power_next;
      if (run) begin
        state_reg    <= state_next;
        rd_valid_reg <= rd_valid_next;
        if (begin_acc) begin
          base_reg <= s_addr_reg[ADDR_W-1:2];
        end
        if (op_read) begin
          rd_data_reg <= rd_word;
        end
      end
    end
  end

  // array write completes at the edge after sampling, no external pulse
  always_ff @(posedge clk) begin
    if (op_write) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[eff_addr][i*LANE_W +: LANE_W] <= s_data_reg[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign data_byte_lanes_out = rd_data_reg;
  // enable is gated live by the pin, so the drivers follow it without a clock
  assign data_byte_lanes_oe  = rd_valid_reg && !output_enable_n;
  assign low_power           = low_power_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_issue;
    op_read ##0 !sleep_request;
  endsequence

  sequence s_read_shown;
    rd_valid_reg ##0 (data_byte_lanes_out == $past(rd_word));
  endsequence

  chk_read_pipe: assert property (s_read_issue |=> s_read_shown)
    else $error("read data not in output register one clock later");
  chk_input_capture: assert property (run |=> s_addr_reg == $past(address_in))
    else $error("address not captured on the edge");
  chk_global_lanes: assert property (!s_gw_n_reg |-> lane_we == LANES_ALL)
    else $error("global write did not enable every lane");
  chk_byte_lanes: assert property ((s_gw_n_reg && !s_bwq_n_reg) |-> lane_we == ~s_bw_n_reg)
    else $error("byte lanes do not follow byte writes");
  chk_deselect_idle: assert property (deselect |=> state_reg == PBS_IDLE && !rd_valid_reg)
    else $error("inactive enable did not deselect");
  chk_processor_addr_strobe_n_read_only: assert property ((processor_addr_strobe_n_take && run) |-> !op_write && !deselect || !en_ok)
    else $error("processor strobe began a write");
  chk_processor_addr_strobe_n_ce1_blocked: assert property ((!s_processor_addr_strobe_n_n_reg && s_ce1_n_reg && s_controller_addr_strobe_n_n_reg) |-> !start)
    else $error("processor strobe acted with enable1 high");
  // the counter itself must hold as well, not only the address picked this cycle
  chk_suspend_hold: assert property ((active && s_adv_n_reg) |-> eff_low == burst.cur_bits ##1 $stable(burst.cur_bits))
    else $error("suspended burst moved its address");
  chk_sleep_freeze: assert property (sleep_request |=> $stable(state_reg) && low_power_reg)
    else $error("sleep did not freeze the port");
  chk_oe_async: assert property (output_enable_n |-> !data_byte_lanes_oe)
    else $error("lanes driven with output enable high");
endmodule
`default_nettype wire

// ===== pbs_bus_model.sv
// far-side bus model: drives every pin of the port but order select once per cycle
`timescale 1ns/100ps
`default_nettype none
module pbs_bus_model
  import pbs_pkg::*;
(
  // clock
  input  wire logic         clk,
  // address and strobes
  output logic [ADDR_W-1:0] address_in,
  output logic              controller_addr_strobe_n,
  output logic              processor_addr_strobe_n,
  output logic              burst_advance_n,
  output logic              burst_order_select,
  // chip enables
  output logic              chip_enable1_n,
  output logic              chip_enable2,
  output logic              chip_enable3_n,
  // write controls
  output logic [LANES-1:0]  byte_write_n,
  output logic              global_write_n,
  output logic              byte_write_qualifier_n,
  // asynchronous controls
  output logic              output_enable_n,
  output logic              sleep_request,
  // host side of the data lanes
  output logic [DATA_W-1:0] host_data
);
  initial begin
    address_in = ADDR_RST;
    burst_order_select = 1'b0;
    host_data = DATA_RST;
    {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, chip_enable1_n, chip_enable2,
     chip_enable3_n, byte_write_n, global_write_n, byte_write_qualifier_n, output_enable_n,
     sleep_request} = 14'h3EFC;
  end

  // only called while the port is held in reset, so the pin never moves in use
  task automatic set_order(input logic o);
    burst_order_select = o;
  endtask

  // c: strobes, advance, enables, byte writes, global, qualifier, output enable, sleep
  task automatic drive(input logic [ADDR_W-1:0] a, input logic [13:0] c, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    address_in = a;
    {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, chip_enable1_n, chip_enable2,
     chip_enable3_n, byte_write_n, global_write_n, byte_write_qualifier_n, output_enable_n, sleep_request} = c;
    host_data = d;
  endtask
endmodule
`default_nettype wire

// ===== test_pipelined_burst_sram_port.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_burst_sram_port;
  import pbs_pkg::*;
  typedef struct packed {logic rd; logic [DATA_W-1:0] d; logic lp; logic ck;} pbs_note_s;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] address_in, base, a;
  logic              controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, burst_order_select;
  logic              chip_enable1_n, chip_enable2, chip_enable3_n, global_write_n, byte_write_qualifier_n;
  logic              output_enable_n, sleep_request, data_byte_lanes_oe, low_power, rd, lp, lq, en, b;
  logic [LANES-1:0]  byte_write_n, ln;
  logic [DATA_W-1:0] host_data, data_byte_lanes_out, dr, seed = 32'h42;
  wire  [DATA_W-1:0] data_byte_lanes_in;
  logic [DATA_W-1:0] mem_ref [16];
  logic [1:0]        st, beat;
  pbs_note_s         notes[$], n;
  int                miscompares = 0, compares = 0;

  pbs_sram_port dut (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .address_in               (address_in),
    .controller_addr_strobe_n (controller_addr_strobe_n),
    .processor_addr_strobe_n  (processor_addr_strobe_n),
    .burst_advance_n          (burst_advance_n),
    .burst_order_select       (burst_order_select),
    .chip_enable1_n           (chip_enable1_n),
    .chip_enable2             (chip_enable2),
    .chip_enable3_n           (chip_enable3_n),
    .byte_write_n             (byte_write_n),
    .global_write_n           (global_write_n),
    .byte_write_qualifier_n   (byte_write_qualifier_n),
    .output_enable_n          (output_enable_n),
    .sleep_request            (sleep_request),
    .data_byte_lanes_in       (data_byte_lanes_in),
    .data_byte_lanes_out      (data_byte_lanes_out),
    .data_byte_lanes_oe       (data_byte_lanes_oe),
    .low_power                (low_power)
  );
  pbs_bus_model m (
    .clk                      (clk),
    .address_in               (address_in),
    .controller_addr_strobe_n (controller_addr_strobe_n),
    .processor_addr_strobe_n  (processor_addr_strobe_n),
    .burst_advance_n          (burst_advance_n),
    .burst_order_select       (burst_order_select),
    .chip_enable1_n           (chip_enable1_n),
    .chip_enable2             (chip_enable2),
    .chip_enable3_n           (chip_enable3_n),
    .byte_write_n             (byte_write_n),
    .global_write_n           (global_write_n),
    .byte_write_qualifier_n   (byte_write_qualifier_n),
    .output_enable_n          (output_enable_n),
    .sleep_request            (sleep_request),
    .host_data                (host_data)
  );
  // bus resolution: the port drives only while its enable is up
  assign data_byte_lanes_in = data_byte_lanes_oe ? data_byte_lanes_out : host_data;
  always #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // reference: notes what each sampled cycle must produce one clock later
  always @(posedge clk) begin
    if (!rst_n) begin
      {rd, lp, dr, st} = '0;
      notes.delete();
    end else if (sleep_request) begin
      lp = 1'b1;
      if (notes.size() > 0) notes[$].ck = 1'b0;
      notes.push_back({rd, dr, lp, 1'b0});
    end else begin
      // low power drops one edge after the begin is sampled, so the note keeps the old level
      lq = lp;
      en = !chip_enable1_n && chip_enable2 && !chip_enable3_n;
      ln = !global_write_n ? LANES_ALL : (!byte_write_qualifier_n ? ~byte_write_n : LANES_NONE);
      b = (!processor_addr_strobe_n && !chip_enable1_n) || !controller_addr_strobe_n;
      if (b) begin
        st = !en ? 2'h0 : ((processor_addr_strobe_n && ln != LANES_NONE) ? 2'h2 : 2'h1);
        base = address_in;
        beat = 2'h0;
        if (en) lp = 1'b0;
      end else if (st != 2'h0 && !lp) begin
        beat = beat + {1'b0, !burst_advance_n};
        st = (ln != LANES_NONE) ? 2'h2 : 2'h1;
      end else st = 2'h0;
      a = {base[15:2], burst_order_select ? base[1:0] ^ beat : base[1:0] + beat};
      for (int i = 0; i < LANES; i++)
        if (st == 2'h2 && ln[i]) mem_ref[a[3:0]][8*i+:8] = data_byte_lanes_in[8*i+:8];
      rd = (st == 2'h1);
      if (rd) dr = mem_ref[a[3:0]];
      notes.push_back({rd, dr, lq, 1'b1});
    end
  end

  // watcher: oldest note against what the port shows one clock on
  always @(posedge clk) begin
    #2;
    if (rst_n && notes.size() > 1) begin
      n = notes.pop_front();
      if (n.ck) check({31'h0, n.rd & !output_enable_n}, {31'h0, data_byte_lanes_oe});
      if (n.ck) check(n.d, data_byte_lanes_out);
      if (notes[0].ck) check({31'h0, notes[0].lp}, {31'h0, low_power});
    end
  end

  initial begin
    logic [31:0] r;
    logic [11:0] hi;
    hi = 12'(rnd() >> 8);
    for (int o = 0; o < 2; o++) begin
      rst_n = 1'b0;
      m.set_order(o[0]);
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      // whole test block written first so no read meets an unknown word
      for (int i = 0; i < 16; i++) m.drive({hi, i[3:0]}, 14'h1AF4, rnd());
      for (int i = 0; i < 1500; i++) begin
        r = rnd();
        m.drive({hi, r[3:0]}, {r[13] | r[20], r[12] | r[21], r[11:1], 1'b0}, rnd());
      end
      // read, suspend, sleep, ignored continue, fresh read
      m.drive({hi, 4'h5}, 14'h1AFC, rnd());
      m.drive({hi, 4'h9}, 14'h3EFC, rnd());
      repeat (3) m.drive({hi, 4'h9}, 14'h3EFD, rnd());
      repeat (2) m.drive({hi, 4'h9}, 14'h36FC, rnd());
      m.drive({hi, 4'h6}, 14'h1AFC, rnd());
      repeat (3) m.drive({hi, 4'h6}, 14'h36FC, rnd());
      // let the last beats reach the watcher before reset cuts them off
      repeat (4) @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
